// >>> common/adc_seq_map.vh
// Constants for the converter sequencing and timing block
`ifndef ADC_SEQ_MAP_VH
`define ADC_SEQ_MAP_VH
// System clock rate in MHz
`define MCLK_MHZ 20
// Power-on hold time and reference settling time in microseconds
`define POR_US 500
`define REF_SETTLE_US 25
// Half-oscillator tick: 20 MHz * 1024 / 10000 = 2.048 MHz
`define HALF_INC 14'h0400
`define HALF_MOD 14'h2710
// Modulator clock toggles every four half ticks (oscillator / 4)
`define MOD_TOGGLE 2'h3
// Start delay of continuous mode, in half ticks (28.5 clocks)
`define START_HALF 17'h00039
// Continuous conversion periods, oscillator clocks
`define CONT_20 16'hC7F8
`define CONT_90 16'h2D0C
`define CONT_330 16'h0C2C
`define CONT_1000 16'h040C
// Single-shot latch-to-ready times, oscillator clocks
`define SING_20 16'hC80D
`define SING_90 16'h2D25
`define SING_330 16'h0C45
`define SING_1000 16'h0425
// Data rate codes
`define DR_20 2'h0
`define DR_90 2'h1
`define DR_330 2'h2
`define DR_1000 2'h3
// Ready output release ahead of an unread result, half ticks
`define DRH_HALF 17'h00010
// Command byte codes
`define CMD_RESET_A 8'h06
`define CMD_RESET_B 8'h07
`define CMD_START 8'h08
`define CMD_SLEEP 8'h02
// Configuration field positions and default
`define CFG_VREF 0
`define CFG_CM 1
`define CFG_DR_LO 2
`define CFG_DR_HI 3
`define CFG_GAIN 4
`define CFG_MUX_LO 5
`define CFG_MUX_HI 7
`define CFG_DEFAULT 8'h00
// Mux code shorting both inputs to mid-supply
`define MUX_SHORT 3'h7
`endif

// >>> verilog/adc_conversion_sequencer.v
// Conversion sequencer: reference, oscillator timing, modes, resets
`timescale 1ns/10ps
`include "adc_seq_map.vh"
//
// Behaviour
// R1 - Config bit picks internal or external reference
// R2 - Internal reference settles within 25 us
// R3 - External reference enables reference input buffers
// R4 - Modulator clock is oscillator divided by four
// R5 - Filter decimation follows selected data rate
// R6 - Continuous period 51192 or 11532 clocks
// R7 - Continuous period 3116 or 1036 clocks
// R8 - Single-shot 51213 or 11557 clocks to ready
// R9 - Single-shot 3141 or 1061 clocks to ready
// R10 - Continuous start waits extra 28.5 clocks
// R11 - Commands latch and time from eighth edge
// R12 - Mux option shorts inputs to mid-supply
// R13 - Host averages shorted readings, subtracts offset
// R14 - Power-on, pin and command reset sources
// R15 - Any reset aborts activity at once
// R16 - Reset loads defaults, sleeps, awaits start
// R17 - Hold reset 500 us after power-up
// R18 - Config bit picks single-shot or continuous
// R19 - Sleep command lets running conversion finish
// R20 - Ready low on result, high once latched
// R21 - Host issues start after changing mode
// R22 - Command codes 06h and 07h reset
// R23 - Start wakes device, mode per config
// R24 - One counter times everything, half-tick resolution; power-on hold and reference settling use own clock-rate counters
module adc_conversion_sequencer
#(
   parameter [13:0] POR_CYCLES = `POR_US * `MCLK_MHZ
)
(
   // Clock and power-on reset
   input wire mclk_in,
   input wire arst_n_in,
   // Reset pin, asynchronous to the clock
   input wire reset_pin_n_in,
   // Command byte, pulse on the eighth serial clock falling edge
   input wire cmd_latch_in,
   input wire [7:0] cmd_byte_in,
   // Configuration write from the serial front end
   input wire cfg_write_in,
   input wire [7:0] cfg_data_in,
   // Result taken for transmission
   input wire result_latched_in,
   // Configuration and reference control
   output reg [7:0] cfg_out,
   output wire ref_ext_sel_out,
   output wire ref_buf_en_out,
   output wire ref_ready_out,
   // Mux and gain steering
   output wire [2:0] mux_sel_out,
   output wire offset_short_out,
   output wire gain_sel_out,
   // Modulator and filter control
   output reg modulator_rate_out,
   output wire [1:0] decim_rate_out,
   output reg sample_strobe_out,
   // Status
   output wire sleep_out,
   output wire converting_out,
   output wire comm_ready_out,
   // Result ready, open-drain
   output reg result_ready_n_out,
   output wire result_ready_oe_out
);

localparam [1:0] ST_SLEEP = 2'h0;
localparam [1:0] ST_DELAY = 2'h1;
localparam [1:0] ST_CONV = 2'h2;
localparam [9:0] SETTLE_LOAD = `REF_SETTLE_US * `MCLK_MHZ;

// Conversion length in half ticks for a rate and mode
function [16:0] conv_half;
   input [1:0] rate;
   input single;
   reg [15:0] clocks;
   begin
      clocks = `CONT_20;
      case (rate)
         `DR_20: clocks = single ? `SING_20 : `CONT_20;
         `DR_90: clocks = single ? `SING_90 : `CONT_90;
         `DR_330: clocks = single ? `SING_330 : `CONT_330;
         `DR_1000: clocks = single ? `SING_1000 : `CONT_1000;
         default: clocks = `CONT_20;
      endcase
      conv_half = {clocks, 1'b0};
   end
endfunction

reg pin_s1;
reg pin_s2;
reg [13:0] por_cnt;
reg por_done;
reg [13:0] acc;
reg half_tick;
reg [1:0] mod_div;
reg [1:0] state;
reg [16:0] cnt;
reg pend_sleep;
reg [9:0] settle_cnt;

wire [1:0] rate = cfg_out[`CFG_DR_HI:`CFG_DR_LO];
wire cont_mode = cfg_out[`CFG_CM];
wire cmd_ok = cmd_latch_in & por_done & pin_s2;
wire cmd_reset = cmd_ok & ((cmd_byte_in == `CMD_RESET_A) |
                           (cmd_byte_in == `CMD_RESET_B)); // R22
wire cmd_start = cmd_ok & (cmd_byte_in == `CMD_START);
wire cmd_sleep = cmd_ok & (cmd_byte_in == `CMD_SLEEP);
wire cfg_wr = cfg_write_in & por_done & pin_s2;
wire busy = (state != ST_SLEEP);
// Config write during a conversion restarts it
wire restart = cmd_start | (cfg_wr & busy);
wire [14:0] acc_sum = {1'b0, acc} + {1'b0, `HALF_INC};
wire ref_switch_int = cfg_wr & cfg_out[`CFG_VREF] & ~cfg_data_in[`CFG_VREF];

// Any reset source funnels into one synchronous clear
wire soft_rst = ~pin_s2 | cmd_reset | ~por_done; // R14 R15

// Reset pin synchroniser; only the second stage is read
always @(posedge mclk_in or negedge arst_n_in)
begin
   if (!arst_n_in)
   begin
      pin_s1 <= 1'b0;
      pin_s2 <= 1'b0;
   end
   else
   begin
      pin_s1 <= reset_pin_n_in;
      pin_s2 <= pin_s1;
   end
end

// Power-on hold; commands are ignored until it ends
always @(posedge mclk_in or negedge arst_n_in)
begin
   if (!arst_n_in)
   begin
      por_cnt <= 14'h0000;
      por_done <= 1'b0;
   end
   else if (!por_done)
   begin
      if (por_cnt >= POR_CYCLES - 14'h0001)
         por_done <= 1'b1; // R17
      else
         por_cnt <= por_cnt + 14'h0001;
   end
end

// Fractional divider gives half-oscillator ticks at 2.048 MHz.
// Realigned on start so latch-relative times do not jitter.
always @(posedge mclk_in or negedge arst_n_in)
begin
   if (!arst_n_in)
   begin
      acc <= 14'h0000;
      half_tick <= 1'b0;
   end
   else if (soft_rst || (state == ST_SLEEP && !cmd_start))
   begin
      acc <= 14'h0000;
      half_tick <= 1'b0;
   end
   else if (cmd_start)
   begin
      acc <= 14'h0000; // R11
      half_tick <= 1'b0;
   end
   else if (acc_sum >= {1'b0, `HALF_MOD})
   begin
      acc <= acc_sum[13:0] - `HALF_MOD; // R24
      half_tick <= 1'b1;
   end
   else
   begin
      acc <= acc_sum[13:0];
      half_tick <= 1'b0;
   end
end

// Modulator clock: oscillator / 4, stopped in the low-power state
always @(posedge mclk_in or negedge arst_n_in)
begin
   if (!arst_n_in)
   begin
      mod_div <= 2'h0;
      modulator_rate_out <= 1'b0;
   end
   else if (soft_rst || !busy)
   begin
      mod_div <= 2'h0;
      modulator_rate_out <= 1'b0;
   end
   else if (half_tick)
   begin
      mod_div <= mod_div + 2'h1;
      if (mod_div == `MOD_TOGGLE)
         modulator_rate_out <= ~modulator_rate_out; // R4
   end
end

// Reference settling after power-up, wake or switch to internal
always @(posedge mclk_in or negedge arst_n_in)
begin
   if (!arst_n_in)
      settle_cnt <= SETTLE_LOAD;
   else if (soft_rst)
      settle_cnt <= SETTLE_LOAD;
   else if ((cmd_start && !busy) || ref_switch_int)
      settle_cnt <= SETTLE_LOAD; // R2
   else if (settle_cnt != 10'h000)
      settle_cnt <= settle_cnt - 10'h001;
end

// Sequencer: one counter for start delay and conversions
always @(posedge mclk_in or negedge arst_n_in)
begin
   if (!arst_n_in)
   begin
      cfg_out <= `CFG_DEFAULT;
      state <= ST_SLEEP;
      cnt <= 17'h00000;
      pend_sleep <= 1'b0;
      result_ready_n_out <= 1'b1;
      sample_strobe_out <= 1'b0;
   end
   else if (soft_rst)
   begin
      cfg_out <= `CFG_DEFAULT; // R16
      state <= ST_SLEEP; // R15
      cnt <= 17'h00000;
      pend_sleep <= 1'b0;
      result_ready_n_out <= 1'b1;
      sample_strobe_out <= 1'b0;
   end
   else
   begin
      sample_strobe_out <= 1'b0;
      if (cfg_wr)
         cfg_out <= cfg_data_in;
      // Latch for transmission releases ready
      if (result_latched_in)
         result_ready_n_out <= 1'b1; // R20
      if (cmd_sleep && busy)
         pend_sleep <= 1'b1; // R19
      if (restart)
      begin
         // Mode taken at the start, as set before it
         pend_sleep <= 1'b0;
         if (cont_mode) // R18 R23
         begin
            state <= ST_DELAY;
            cnt <= `START_HALF - 17'h00001; // R10
         end
         else
         begin
            state <= ST_CONV;
            cnt <= conv_half(rate, 1'b1) - 17'h00001; // R8 R9
         end
      end
      else if (busy && half_tick)
      begin
         if (cnt != 17'h00000)
         begin
            cnt <= cnt - 17'h00001;
            // Unread result: release ready before next one lands
            if (state == ST_CONV && cont_mode && cnt == `DRH_HALF)
               result_ready_n_out <= 1'b1;
         end
         else if (state == ST_DELAY)
         begin
            state <= ST_CONV;
            cnt <= conv_half(rate, 1'b0) - 17'h00001; // R6 R7
         end
         else
         begin
            // New result; fall wins over a same-cycle latch
            result_ready_n_out <= 1'b0; // R20
            sample_strobe_out <= 1'b1;
            if (cont_mode && !pend_sleep && !cmd_sleep)
               cnt <= conv_half(rate, 1'b0) - 17'h00001; // R6 R7
            else
            begin
               state <= ST_SLEEP; // R19
               pend_sleep <= 1'b0;
            end
         end
      end
   end
end

// Reference selection and buffers
assign ref_ext_sel_out = cfg_out[`CFG_VREF]; // R1
assign ref_buf_en_out = cfg_out[`CFG_VREF] & busy; // R3
assign ref_ready_out = busy & (settle_cnt == 10'h000); // R2

// Input steering; offset is measured with inputs shorted
assign mux_sel_out = cfg_out[`CFG_MUX_HI:`CFG_MUX_LO];
assign offset_short_out = (mux_sel_out == `MUX_SHORT); // R12
assign gain_sel_out = cfg_out[`CFG_GAIN];
assign decim_rate_out = rate; // R5

// Status and open-drain drive
assign sleep_out = ~busy;
assign converting_out = (state == ST_CONV);
assign comm_ready_out = por_done & pin_s2;
assign result_ready_oe_out = ~result_ready_n_out;

endmodule // adc_conversion_sequencer

// >>> bench/adc_seq_checker_assertions.sv
// Port checker for the conversion sequencer, bound into the design
`timescale 1ns/10ps
module adc_seq_checker
(
   // Clock, reset and host strobes
   input wire mclk_in,
   input wire arst_n_in,
   input wire cmd_latch_in,
   input wire [7:0] cmd_byte_in,
   input wire cfg_write_in,
   input wire result_latched_in,
   // Configuration and steering
   input wire [7:0] cfg_out,
   input wire ref_ext_sel_out,
   input wire ref_buf_en_out,
   input wire [2:0] mux_sel_out,
   input wire offset_short_out,
   // Status and ready
   input wire sample_strobe_out,
   input wire sleep_out,
   input wire converting_out,
   input wire comm_ready_out,
   input wire result_ready_n_out,
   input wire result_ready_oe_out
);
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!arst_n_in);
   chk_oe_mirror: assert property (result_ready_oe_out == !result_ready_n_out)
      else $error("ready enable does not mirror ready");
   chk_ref_select: assert property (ref_ext_sel_out == cfg_out[0])
      else $error("reference select off its config bit");
   chk_ref_buffers: assert property (ref_buf_en_out == (ref_ext_sel_out && !sleep_out))
      else $error("reference buffers wrong");
   chk_short_inputs: assert property (mux_sel_out == cfg_out[7:5]
      && offset_short_out == (cfg_out[7:5] == 3'h7)) else $error("short select wrong");
   // Either reset code clears everything at the taking edge
   chk_reset_cmd: assert property (cmd_latch_in && comm_ready_out && cmd_byte_in[7:1] == 7'h03
      |=> cfg_out == 8'h00 && sleep_out && !converting_out && result_ready_n_out)
      else $error("reset command did not clear");
   chk_locked_cfg: assert property (cfg_write_in && !comm_ready_out |=> $stable(cfg_out))
      else $error("write taken during hold");
   chk_ready_strobe: assert property (sample_strobe_out |-> !result_ready_n_out)
      else $error("result without ready");
   // A latch on the completing edge loses to the new result, seen as the strobe
   chk_latch_release: assert property (result_latched_in
      |=> result_ready_n_out || sample_strobe_out) else $error("ready not released");
   chk_fall_strobe: assert property ($fell(result_ready_n_out) |-> sample_strobe_out)
      else $error("ready fell without a result");
   chk_sleep_idle: assert property (sleep_out |-> !converting_out)
      else $error("converting while asleep");
endmodule // adc_seq_checker
bind adc_conversion_sequencer adc_seq_checker i_chk (.mclk_in(mclk_in), .arst_n_in(arst_n_in),
   .cmd_latch_in(cmd_latch_in), .cmd_byte_in(cmd_byte_in), .cfg_write_in(cfg_write_in),
   .result_latched_in(result_latched_in), .cfg_out(cfg_out), .ref_ext_sel_out(ref_ext_sel_out),
   .ref_buf_en_out(ref_buf_en_out), .mux_sel_out(mux_sel_out),
   .offset_short_out(offset_short_out), .sample_strobe_out(sample_strobe_out),
   .sleep_out(sleep_out), .converting_out(converting_out), .comm_ready_out(comm_ready_out),
   .result_ready_n_out(result_ready_n_out), .result_ready_oe_out(result_ready_oe_out));

// >>> bench/adc_host_model.sv
// Host-side model driving commands, configuration and result reads
`timescale 1ns/10ps
module adc_host_model
(
   // Clock
   input wire mclk_in,
   // Strobes toward the sequencer
   output logic cmd_latch_out,
   output logic [7:0] cmd_byte_out,
   output logic cfg_write_out,
   output logic [7:0] cfg_data_out,
   output logic result_latched_out
);
   // Quiet at time zero
   initial
   begin
      cmd_latch_out = 1'b0;
      cmd_byte_out = 8'hFF;
      cfg_write_out = 1'b0;
      cfg_data_out = 8'hFF;
      result_latched_out = 1'b0;
   end
   // Bytes inverted after use so a stale value never reads as valid
   task send_cmd(input logic [7:0] b);
      @(posedge mclk_in);
      #1;
      cmd_byte_out = b;
      cmd_latch_out = 1'b1;
      @(posedge mclk_in);
      #1;
      cmd_latch_out = 1'b0;
      cmd_byte_out = ~b;
   endtask
   task write_cfg(input logic [7:0] d);
      @(posedge mclk_in);
      #1;
      cfg_data_out = d;
      cfg_write_out = 1'b1;
      @(posedge mclk_in);
      #1;
      cfg_write_out = 1'b0;
      cfg_data_out = ~d;
   endtask
   // Result read; shorted-input offset averaging is left to host firmware
   task take_result;
      @(posedge mclk_in);
      #1;
      result_latched_out = 1'b1;
      @(posedge mclk_in);
      #1;
      result_latched_out = 1'b0;
   endtask
endmodule // adc_host_model

// >>> bench/tb.sv
// Self-checking bench for the conversion sequencer
`timescale 1ns/10ps
`include "adc_seq_map.vh"
module tb;
   logic mclk_in, arst_n_in, reset_pin_n_in;
   wire cmd_latch_in, cfg_write_in, result_latched_in;
   wire [7:0] cmd_byte_in, cfg_data_in, cfg_out;
   wire [2:0] mux_sel_out;
   wire [1:0] decim_rate_out;
   wire ref_ext_sel_out, ref_buf_en_out, ref_ready_out, offset_short_out, gain_sel_out;
   wire modulator_rate_out, sample_strobe_out, sleep_out, converting_out, comm_ready_out;
   wire result_ready_n_out, result_ready_oe_out;
   int errors, checks, cycles, n, t;
   adc_conversion_sequencer #(.POR_CYCLES(14'h0014)) i_adc_conversion_sequencer (
      .mclk_in(mclk_in), .arst_n_in(arst_n_in), .reset_pin_n_in(reset_pin_n_in),
      .cmd_latch_in(cmd_latch_in), .cmd_byte_in(cmd_byte_in), .cfg_write_in(cfg_write_in),
      .cfg_data_in(cfg_data_in), .result_latched_in(result_latched_in), .cfg_out(cfg_out),
      .ref_ext_sel_out(ref_ext_sel_out), .ref_buf_en_out(ref_buf_en_out),
      .ref_ready_out(ref_ready_out), .mux_sel_out(mux_sel_out),
      .offset_short_out(offset_short_out), .gain_sel_out(gain_sel_out),
      .modulator_rate_out(modulator_rate_out), .decim_rate_out(decim_rate_out),
      .sample_strobe_out(sample_strobe_out), .sleep_out(sleep_out),
      .converting_out(converting_out), .comm_ready_out(comm_ready_out),
      .result_ready_n_out(result_ready_n_out), .result_ready_oe_out(result_ready_oe_out));
   adc_host_model i_adc_host_model (.mclk_in(mclk_in), .cmd_latch_out(cmd_latch_in),
      .cmd_byte_out(cmd_byte_in), .cfg_write_out(cfg_write_in), .cfg_data_out(cfg_data_in),
      .result_latched_out(result_latched_in));
   initial
   begin
      mclk_in = 1'b0;
      forever #25 mclk_in = ~mclk_in;
   end
   task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("wrong value %s expected %0h seen %0h", name, exp, seen);
      end
   endtask
   // Counts are matched to within three cycles of tick jitter
   task near(input string name, input int seen, input int exp);
      check(name, (seen > exp - 4 && seen < exp + 4) ? exp : seen, exp);
   endtask
   // Cycles and modulator toggles up to the next ready fall
   task wait_fall;
      logic prev, m;
      n = 0;
      t = 0;
      prev = result_ready_n_out;
      m = modulator_rate_out;
      while (!(prev === 1'b1 && result_ready_n_out === 1'b0) && n < 60000)
      begin
         prev = result_ready_n_out;
         @(posedge mclk_in);
         #1;
         n++;
         t += (modulator_rate_out !== m);
         m = modulator_rate_out;
      end
   endtask
   task complete_run;
      if (errors == 0 && checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // Hang guard
   always @(posedge mclk_in)
   begin
      cycles++;
      if (cycles == 100000)
      begin
         errors++;
         complete_run;
      end
   end
   initial
   begin
      arst_n_in = 1'b0;
      reset_pin_n_in = 1'b1;
      repeat (6) @(posedge mclk_in);
      #1;
      arst_n_in = 1'b1;
      i_adc_host_model.write_cfg(8'hFF);
      check("cfg_locked", cfg_out, 8'h00);
      check("idle", {sleep_out, result_ready_n_out, ref_ext_sel_out}, 3'h6);
      // Sample after the edge has settled, never in its own time step
      for (n = 0; n < 100 && comm_ready_out !== 1'b1; n++)
      begin
         @(posedge mclk_in);
         #1;
      end
      near("por_hold", n, 18);
      i_adc_host_model.write_cfg(8'hED);
      check("steer", {gain_sel_out, ref_ext_sel_out, ref_buf_en_out, offset_short_out,
         decim_rate_out, mux_sel_out}, 9'h0BF);
      i_adc_host_model.send_cmd(`CMD_START);
      check("wake", {sleep_out, converting_out, ref_buf_en_out}, 3'h3);
      wait_fall;
      near("single_time", n, `SING_1000 * 10000 / 512);
      near("mod_toggles", t, `SING_1000 / 2);
      @(posedge mclk_in);
      #1;
      check("single_end", {sleep_out, result_ready_n_out, result_ready_oe_out}, 3'h5);
      i_adc_host_model.take_result;
      check("released", result_ready_n_out, 1'h1);
      // Mode change followed by a start
      i_adc_host_model.write_cfg(8'h0E);
      i_adc_host_model.send_cmd(`CMD_START);
      wait_fall;
      near("cont_first", n, (57 + 2 * `CONT_1000) * 10000 / 1024);
      wait_fall;
      near("cont_period", n, `CONT_1000 * 10000 / 512);
      i_adc_host_model.send_cmd(`CMD_SLEEP);
      check("sleep_wait", {sleep_out, converting_out}, 2'h1);
      wait_fall;
      near("last_result", n, `CONT_1000 * 10000 / 512 - 2);
      @(posedge mclk_in);
      #1;
      check("asleep", sleep_out, 1'h1);
      // Single-shot start on the internal reference, wait for it to settle
      i_adc_host_model.write_cfg(8'h0C);
      i_adc_host_model.send_cmd(`CMD_START);
      for (n = 0; n < 600 && ref_ready_out !== 1'b1; n++)
      begin
         @(posedge mclk_in);
         #1;
      end
      check("ref_settle", n <= 500, 1'h1);
      // Config write while busy restarts, timed at the old rate; decimation shows the new one
      i_adc_host_model.write_cfg(8'h04);
      check("restart", {converting_out, decim_rate_out}, 3'h5);
      i_adc_host_model.send_cmd(8'h07);
      check("abort", {cfg_out, sleep_out, converting_out}, 10'h002);
      i_adc_host_model.write_cfg(8'h0D);
      i_adc_host_model.send_cmd(8'h06);
      check("reset06", cfg_out, 8'h00);
      i_adc_host_model.write_cfg(8'h0D);
      i_adc_host_model.send_cmd(`CMD_START);
      reset_pin_n_in = 1'b0;
      repeat (4) @(posedge mclk_in);
      #1;
      check("pin_reset", {cfg_out, sleep_out, comm_ready_out}, 10'h002);
      reset_pin_n_in = 1'b1;
      repeat (3) @(posedge mclk_in);
      #1;
      check("pin_release", comm_ready_out, 1'h1);
      complete_run;
   end
endmodule // tb
